// >>> fptc_pkg.sv
`default_nettype none

package fptc_pkg;

	// ------------------------------------------------------------
	// memory map of the processor bus
	// ------------------------------------------------------------
	localparam logic [31:0] SRAM_BASE   = 32'h2000_0000; // sram window start
	localparam logic [31:0] SRAM_BYTES  = 32'h0000_8000; // 32 kb of sram
	localparam logic [31:0] BB_BASE     = 32'h2200_0000; // bit alias window start
	localparam logic [31:0] BB_SPAN     = 32'h0010_0000; // sram bytes times 32
	localparam logic [31:0] FLASH_BYTES = 32'h0001_8000; // 96 kb of flash
	localparam int          BB_BYTE_SH  = 5;             // alias bytes per sram byte, log2 of 32
	localparam int          BB_BIT_SH   = 2;             // alias bytes per bit, log2 of 4
	localparam int          PROT_SH     = 11;            // 2 kb protection block
	localparam int          ERASE_SH    = 10;            // 1 kb erase block
	localparam int          PROT_BITS   = 48;            // flash bytes / 2 kb

	// ------------------------------------------------------------
	// register offsets, byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_TARGET = 8'h00; // flash_target_address
	localparam logic [7:0] OFS_DATA   = 8'h04; // program data word
	localparam logic [7:0] OFS_CTRL   = 8'h08; // flash_control
	localparam logic [7:0] OFS_RAW    = 8'h0C; // flash_raw_int_status
	localparam logic [7:0] OFS_MASK   = 8'h10; // flash_int_mask
	localparam logic [7:0] OFS_MISC   = 8'h14; // masked status, write one clears
	localparam logic [7:0] OFS_USEC   = 8'h18; // usec_reload
	localparam logic [7:0] OFS_RD0    = 8'h20; // read_enable_bits low word
	localparam logic [7:0] OFS_RD1    = 8'h24; // read_enable_bits high half
	localparam logic [7:0] OFS_PG0    = 8'h28; // program_enable_bits low word
	localparam logic [7:0] OFS_PG1    = 8'h2C; // program_enable_bits high half

	// ------------------------------------------------------------
	// fields and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_KEY    = 16'hA442; // write key in bits 31:16
	localparam int          CTRL_WRITE  = 0;        // program one word
	localparam int          CTRL_ERASE  = 1;        // erase one 1 kb block
	localparam int          CTRL_COMMIT = 3;        // commit_bit
	localparam int          INT_ACCESS  = 0;        // access_int_mask position
	localparam int          INT_PROG    = 1;        // programming complete
	localparam logic [7:0]  USEC_RESET  = 8'h18;    // fits the fastest clock
	localparam logic [47:0] PROT_RESET  = 48'hFFFF_FFFF_FFFF;
	localparam logic [1:0]  SEL_RD0     = 2'h0;     // commit selectors
	localparam logic [1:0]  SEL_PG0     = 2'h1;
	localparam logic [1:0]  SEL_RD1     = 2'h2;
	localparam logic [1:0]  SEL_PG1     = 2'h3;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        valid; // request present
		logic        write; // store, else load
		logic        fetch; // instruction fetch
		logic [31:0] addr;  // byte address, word aligned
		logic [31:0] wdata; // store data
	} fptc_bus_req_s;

	typedef struct packed {
		logic        done;  // one cycle answer
		logic        fault; // bus fault with done
		logic [31:0] rdata; // load data with done
	} fptc_bus_rsp_s;

	typedef struct packed {
		logic        we;    // write word
		logic [12:0] addr;  // word index
		logic [31:0] wdata; // word to store
	} fptc_sram_s;

	typedef struct packed {
		logic        prog;  // program pulse, level
		logic        erase; // erase pulse, level
		logic [14:0] addr;  // word index
		logic [31:0] wdata; // word to program
	} fptc_flash_s;

	typedef struct packed {
		logic        commit; // one cycle commit strobe
		logic [1:0]  sel;    // which protection word
		logic [31:0] data;   // value made permanent
	} fptc_nv_s;

endpackage : fptc_pkg

`default_nettype wire

// >>> fptc_bitband.sv
`default_nettype none

// alias address to sram word index and bit number
module fptc_bitband (
	// alias side
	input  wire logic [31:0] addr,
	// decoded target
	output logic             hit,
	output logic [12:0]      word,
	output logic [4:0]       bitn
);

	logic [31:0] off;      // offset into alias window
	logic [31:0] byte_off; // sram byte offset

	// ------------------------------------------------------------
	// alias = base + byte * 32 + bit * 4
	// ------------------------------------------------------------
	always_comb begin
		off      = addr - fptc_pkg::BB_BASE;
		byte_off = off >> fptc_pkg::BB_BYTE_SH;
		hit      = (addr >= fptc_pkg::BB_BASE) && (off < fptc_pkg::BB_SPAN);
		word     = byte_off[14:2];
		bitn     = {byte_off[1:0], off[fptc_pkg::BB_BYTE_SH-1:fptc_pkg::BB_BIT_SH]};
	end

endmodule : fptc_bitband

`default_nettype wire

// >>> fptc_usec_tick.sv
`default_nettype none

// one pulse per microsecond while run is high
module fptc_usec_tick (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       run,
	input  wire logic [7:0] reload,
	// output
	output logic            tick
);

	typedef struct packed {
		logic [7:0] cnt; // cycles left in this microsecond
	} fptc_tick_s;

	fptc_tick_s q, d;

	// ------------------------------------------------------------
	// reload holds cycles per microsecond minus one
	// ------------------------------------------------------------
	always_comb begin
		d    = q;
		tick = run && (q.cnt == 8'h00);
		if (!run) begin
			d.cnt = reload; // restart aligned to the operation
		end else if (q.cnt == 8'h00) begin
			d.cnt = reload;
		end else begin
			d.cnt = q.cnt - 8'h01;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule : fptc_usec_tick

`default_nettype wire

// >>> fptc_top.sv
`default_nettype none

module fptc_top #(
	parameter int PROG_US  = 20,  // program time in microseconds
	parameter int ERASE_US = 250  // erase time in microseconds
) (
	// clock and reset
	input  wire logic                    MCLK,
	input  wire logic                    RSTN,
	// register port
	input  wire logic [7:0]              REG_ADDR,
	input  wire logic [31:0]             REG_WDATA,
	input  wire logic                    REG_WR,
	input  wire logic                    REG_RD,
	output logic [31:0]                  REG_RDATA,
	// processor bus
	input  wire fptc_pkg::fptc_bus_req_s BUS_REQ,
	output logic                         BUS_READY,
	output fptc_pkg::fptc_bus_rsp_s      BUS_RSP,
	// sram array
	output fptc_pkg::fptc_sram_s         SRAM_OUT,
	input  wire logic [31:0]             SRAM_RDATA,
	// flash array
	output fptc_pkg::fptc_flash_s        FLASH_OUT,
	input  wire logic [31:0]             FLASH_RDATA,
	// nonvolatile protection image
	input  wire logic [47:0]             NV_RD_EN,
	input  wire logic [47:0]             NV_PG_EN,
	output fptc_pkg::fptc_nv_s           NV_OUT,
	// interrupt
	output logic                         FLASH_IRQ
);

	// ------------------------------------------------------------
	// state machine and state record
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0, // waiting
		ST_SRAM_RD = 3'h1, // sram word read
		ST_BB_RD   = 3'h2, // alias read, maybe modify
		ST_FL_RD   = 3'h3, // flash read or fetch
		ST_PG_RD   = 3'h4, // fetch old word before program
		ST_OP      = 3'h5  // timed program or erase
	} fptc_st_e;

	typedef struct packed {
		fptc_st_e                st;        // controller state
		logic                    loaded;    // nv image taken
		logic [31:0]             target;    // flash_target_address
		logic [31:0]             pdata;     // program data
		logic [3:0]              ctrl;      // flash_control bits
		logic [1:0]              raw;       // flash_raw_int_status
		logic [1:0]              mask;      // flash_int_mask
		logic [7:0]              usec;      // usec_reload
		logic [47:0]             rd_en;     // read_enable_bits
		logic [47:0]             pg_en;     // program_enable_bits
		logic [15:0]             us_left;   // microseconds left
		logic                    bb_wr;     // alias store pending
		logic                    bb_val;    // alias store value
		logic [4:0]              bb_bit;    // alias bit number
		logic [31:0]             reg_rdata; // register read data
		fptc_pkg::fptc_bus_rsp_s rsp;       // bus answer
		fptc_pkg::fptc_sram_s    sram;      // sram drive
		fptc_pkg::fptc_flash_s   flash;     // flash drive
		fptc_pkg::fptc_nv_s      nv;        // commit drive
	} fptc_state_s;

	fptc_state_s q, d;

	logic        bb_hit;  // alias window hit
	logic [12:0] bb_word; // alias target word
	logic [4:0]  bb_bitn; // alias target bit
	logic        us_tick; // one microsecond passed

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	fptc_bitband u_bitband (
		.addr (BUS_REQ.addr),
		.hit  (bb_hit),
		.word (bb_word),
		.bitn (bb_bitn)
	);

	// runs only while an operation is being timed
	fptc_usec_tick u_tick (
		.clk    (MCLK),
		.rst_n  (RSTN),
		.run    (q.st == ST_OP),
		.reload (q.usec),
		.tick   (us_tick)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// bus waits while busy or while a flash operation is queued
	assign BUS_READY = (q.st == ST_IDLE) && q.loaded && (q.ctrl == 4'h0);
	assign BUS_RSP   = q.rsp;
	assign SRAM_OUT  = q.sram;
	assign FLASH_OUT = q.flash;
	assign NV_OUT    = q.nv;
	assign REG_RDATA = q.reg_rdata;
	assign FLASH_IRQ = |(q.raw & q.mask);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [5:0]  pidx;   // protection index of target
		logic [5:0]  bidx;   // protection index of bus address
		logic        in_fl;  // target inside flash
		logic        b_fl;   // bus address inside flash
		logic        b_sram; // bus address inside sram
		logic [31:0] word;   // alias work word
		pidx   = q.target[fptc_pkg::PROT_SH+5:fptc_pkg::PROT_SH];
		bidx   = BUS_REQ.addr[fptc_pkg::PROT_SH+5:fptc_pkg::PROT_SH];
		in_fl  = q.target < fptc_pkg::FLASH_BYTES;
		b_fl   = BUS_REQ.addr < fptc_pkg::FLASH_BYTES;
		b_sram = (BUS_REQ.addr >= fptc_pkg::SRAM_BASE)
			&& (BUS_REQ.addr - fptc_pkg::SRAM_BASE < fptc_pkg::SRAM_BYTES);
		word   = SRAM_RDATA;
		d           = q;
		d.rsp.done  = 1'b0;
		d.rsp.fault = 1'b0;
		d.sram.we   = 1'b0;
		d.nv.commit = 1'b0;

		// register reads, answered next cycle
		if (REG_RD) begin
			unique case (REG_ADDR)
				fptc_pkg::OFS_TARGET: d.reg_rdata = q.target;
				fptc_pkg::OFS_DATA:   d.reg_rdata = q.pdata;
				fptc_pkg::OFS_CTRL:   d.reg_rdata = {28'h0, q.ctrl};
				fptc_pkg::OFS_RAW:    d.reg_rdata = {30'h0, q.raw};
				fptc_pkg::OFS_MASK:   d.reg_rdata = {30'h0, q.mask};
				fptc_pkg::OFS_MISC:   d.reg_rdata = {30'h0, q.raw & q.mask};
				fptc_pkg::OFS_USEC:   d.reg_rdata = {24'h0, q.usec};
				fptc_pkg::OFS_RD0:    d.reg_rdata = q.rd_en[31:0];
				fptc_pkg::OFS_RD1:    d.reg_rdata = {16'h0, q.rd_en[47:32]};
				fptc_pkg::OFS_PG0:    d.reg_rdata = q.pg_en[31:0];
				fptc_pkg::OFS_PG1:    d.reg_rdata = {16'h0, q.pg_en[47:32]};
				default:              d.reg_rdata = 32'h0;                    // unmapped reads zero
			endcase
		end

		// register writes; hardware events below win over them
		if (REG_WR) begin
			unique case (REG_ADDR)
				fptc_pkg::OFS_TARGET: d.target = REG_WDATA;
				fptc_pkg::OFS_DATA:   d.pdata  = REG_WDATA;
				fptc_pkg::OFS_CTRL: begin
					// without the key the write is dropped
					if (REG_WDATA[31:16] == fptc_pkg::CTRL_KEY) begin
						d.ctrl = q.ctrl | REG_WDATA[3:0];
					end
				end
				fptc_pkg::OFS_MASK: d.mask = REG_WDATA[1:0];
				fptc_pkg::OFS_MISC: d.raw  = q.raw & ~REG_WDATA[1:0];
				fptc_pkg::OFS_USEC: d.usec = REG_WDATA[7:0];
				// protection bits can only go from one to zero
				fptc_pkg::OFS_RD0:  d.rd_en[31:0]  = q.rd_en[31:0] & REG_WDATA;
				fptc_pkg::OFS_RD1:  d.rd_en[47:32] = q.rd_en[47:32] & REG_WDATA[15:0];
				fptc_pkg::OFS_PG0:  d.pg_en[31:0]  = q.pg_en[31:0] & REG_WDATA;
				fptc_pkg::OFS_PG1:  d.pg_en[47:32] = q.pg_en[47:32] & REG_WDATA[15:0];
				default: ;                                                          // ignored
			endcase
		end

		unique case (q.st)
			ST_IDLE: begin
				if (!q.loaded) begin
					// committed image replaces the all-ones reset value
					d.loaded = 1'b1;
					d.rd_en  = NV_RD_EN;
					d.pg_en  = NV_PG_EN;
				end else if (q.ctrl[fptc_pkg::CTRL_COMMIT]) begin
					// commit one protection word, others are ignored
					d.ctrl[fptc_pkg::CTRL_COMMIT] = 1'b0;
					if (q.target[31:2] == 30'h0) begin
						d.nv.commit = 1'b1;
						d.nv.sel    = q.target[1:0];
						unique case (q.target[1:0])
							fptc_pkg::SEL_RD0: d.nv.data = q.rd_en[31:0];
							fptc_pkg::SEL_PG0: d.nv.data = q.pg_en[31:0];
							fptc_pkg::SEL_RD1: d.nv.data = {16'h0, q.rd_en[47:32]};
							fptc_pkg::SEL_PG1: d.nv.data = {16'h0, q.pg_en[47:32]};
						endcase
					end
				end else if (q.ctrl[fptc_pkg::CTRL_WRITE] || q.ctrl[fptc_pkg::CTRL_ERASE]) begin
					if (!in_fl || !q.pg_en[pidx]) begin
						// refused: no array drive, no complete flag
						d.raw[fptc_pkg::INT_ACCESS] = 1'b1;
						d.ctrl[fptc_pkg::CTRL_WRITE] = 1'b0;
						d.ctrl[fptc_pkg::CTRL_ERASE] = 1'b0;
					end else if (q.ctrl[fptc_pkg::CTRL_WRITE]) begin
						d.flash.addr = q.target[16:2];
						d.us_left    = 16'(PROG_US);
						d.st         = ST_PG_RD;
					end else begin
						// erase address rounds down to its 1 kb block
						d.flash.addr  = {q.target[16:fptc_pkg::ERASE_SH], 8'h00};
						d.flash.erase = 1'b1;
						d.us_left     = 16'(ERASE_US);
						d.st          = ST_OP;
					end
				end else if (BUS_REQ.valid) begin
					if (b_fl) begin
						if (BUS_REQ.write) begin
							// flash changes only through the controller
							d.rsp.done  = 1'b1;
							d.rsp.fault = 1'b1;
						end else if (!BUS_REQ.fetch && !q.rd_en[bidx]) begin
							d.rsp.done  = 1'b1;
							d.rsp.fault = 1'b1;
						end else begin
							d.flash.addr = BUS_REQ.addr[16:2];
							d.st         = ST_FL_RD;
						end
					end else if (b_sram) begin
						d.sram.addr = BUS_REQ.addr[14:2];
						if (BUS_REQ.write) begin
							d.sram.we    = 1'b1;
							d.sram.wdata = BUS_REQ.wdata;
							d.rsp.done   = 1'b1;
						end else begin
							d.st = ST_SRAM_RD;
						end
					end else if (bb_hit) begin
						// bus stays held until the alias access ends
						d.sram.addr = bb_word;
						d.bb_wr     = BUS_REQ.write;
						d.bb_val    = BUS_REQ.wdata[0];
						d.bb_bit    = bb_bitn;
						d.st        = ST_BB_RD;
					end else begin
						d.rsp.done  = 1'b1; // nothing mapped here
						d.rsp.fault = 1'b1;
					end
				end
			end
			ST_SRAM_RD: begin
				d.rsp.done  = 1'b1;
				d.rsp.rdata = SRAM_RDATA;
				d.st        = ST_IDLE;
			end
			ST_BB_RD: begin
				// read and, for a store, write back in one held access
				if (q.bb_wr) begin
					word[q.bb_bit] = q.bb_val;
					d.sram.we      = 1'b1;
					d.sram.wdata   = word;
					d.rsp.rdata    = 32'h0;
				end else begin
					d.rsp.rdata = {31'h0, SRAM_RDATA[q.bb_bit]};
				end
				d.rsp.done = 1'b1;
				d.st       = ST_IDLE;
			end
			ST_FL_RD: begin
				d.rsp.done  = 1'b1;
				d.rsp.rdata = FLASH_RDATA;
				d.st        = ST_IDLE;
			end
			ST_PG_RD: begin
				// and with the old word so no zero turns into one
				d.flash.wdata = FLASH_RDATA & q.pdata;
				d.flash.prog  = 1'b1;
				d.st          = ST_OP;
			end
			ST_OP: begin
				// pulse length counted in microseconds
				if (us_tick) begin
					if (q.us_left <= 16'h0001) begin
						d.flash.prog  = 1'b0;
						d.flash.erase = 1'b0;
						d.ctrl[fptc_pkg::CTRL_WRITE] = 1'b0;
						d.ctrl[fptc_pkg::CTRL_ERASE] = 1'b0;
						d.raw[fptc_pkg::INT_PROG]    = 1'b1;
						d.st = ST_IDLE;
					end else begin
						d.us_left = q.us_left - 16'h0001;
					end
				end
			end
			default: d.st = ST_IDLE; // unused codes recover
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			q       <= '0;
			q.usec  <= fptc_pkg::USEC_RESET;
			q.rd_en <= fptc_pkg::PROT_RESET;
			q.pg_en <= fptc_pkg::PROT_RESET;
		end else begin
			q <= d;
		end
	end

endmodule : fptc_top

`default_nettype wire

// >>> fptc_properties.sv
`default_nettype none

// watches processor bus answers and array strobes of the memory controller
module fptc_checker (
	// clock and reset
	input wire logic                    MCLK,
	input wire logic                    RSTN,
	// processor bus
	input wire fptc_pkg::fptc_bus_req_s BUS_REQ,
	input wire logic                    BUS_READY,
	input wire fptc_pkg::fptc_bus_rsp_s BUS_RSP,
	// arrays
	input wire fptc_pkg::fptc_sram_s    SRAM_OUT,
	input wire logic [31:0]             SRAM_RDATA,
	input wire fptc_pkg::fptc_flash_s   FLASH_OUT,
	input wire logic [31:0]             FLASH_RDATA
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);

	// ------------------------------------------------------------
	// accepted requests by region
	// ------------------------------------------------------------
	sequence s_take;
		BUS_REQ.valid && BUS_READY;
	endsequence
	sequence s_sram_wr;
		s_take ##0 (BUS_REQ.write && BUS_REQ.addr[31:15] == 17'h04000);
	endsequence
	sequence s_alias;
		s_take ##0 (BUS_REQ.addr[31:20] == 12'h220);
	endsequence
	sequence s_alias_wr;
		s_alias ##0 BUS_REQ.write;
	endsequence
	sequence s_flash;
		s_take ##0 (BUS_REQ.addr < fptc_pkg::FLASH_BYTES);
	endsequence

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	AST_FAULT_WITH_DONE: assert property (BUS_RSP.fault |-> BUS_RSP.done)
		else $error("fault without done");
	AST_FLASH_STORE_FAULT: assert property (s_flash ##0 BUS_REQ.write |=> BUS_RSP.done && BUS_RSP.fault)
		else $error("flash store not faulted");
	AST_FETCH_PASSES: assert property (s_flash ##0 (BUS_REQ.fetch && !BUS_REQ.write)
		|=> !BUS_RSP.done ##1 (BUS_RSP.done && !BUS_RSP.fault))
		else $error("fetch not answered in two cycles");
	AST_SRAM_STORE: assert property (s_sram_wr
		|=> SRAM_OUT.we && BUS_RSP.done && SRAM_OUT.addr == $past(BUS_REQ.addr[14:2]))
		else $error("sram store misplaced");
	AST_ALIAS_DECODE: assert property (s_alias |=> SRAM_OUT.addr == $past(BUS_REQ.addr[19:7]))
		else $error("alias word index wrong");
	AST_ALIAS_VALUE: assert property (s_alias_wr |-> ##2 (SRAM_OUT.we && BUS_RSP.done
		&& SRAM_OUT.wdata[$past(BUS_REQ.addr[6:2], 2)] == $past(BUS_REQ.wdata[0], 2)))
		else $error("alias bit value wrong");
	AST_ALIAS_ONE_BIT: assert property (s_alias_wr |-> ##2
		((SRAM_OUT.wdata ^ $past(SRAM_RDATA)) & ~(32'h1 << $past(BUS_REQ.addr[6:2], 2))) == 32'h0)
		else $error("alias store touched other bits");
	AST_PROG_CLEARS_ONLY: assert property ($rose(FLASH_OUT.prog) |-> (FLASH_OUT.wdata & ~FLASH_RDATA) == 32'h0)
		else $error("program sets a zero bit");
	AST_ONE_FLASH_OP: assert property (!(FLASH_OUT.prog && FLASH_OUT.erase))
		else $error("program and erase together");
endmodule : fptc_checker

bind fptc_top fptc_checker fptc_checker_inst (.MCLK(MCLK), .RSTN(RSTN), .BUS_REQ(BUS_REQ), .BUS_READY(BUS_READY),
	.BUS_RSP(BUS_RSP), .SRAM_OUT(SRAM_OUT), .SRAM_RDATA(SRAM_RDATA), .FLASH_OUT(FLASH_OUT),
	.FLASH_RDATA(FLASH_RDATA));

`default_nettype wire

// >>> fptc_array_model.sv
`default_nettype none

// asynchronous-read sram and flash arrays behind the controller
module fptc_array_model (
	// clock
	input  wire logic                  clk,
	// sram side
	input  wire fptc_pkg::fptc_sram_s  sram_in,
	output logic [31:0]                sram_rdata,
	// flash side
	input  wire fptc_pkg::fptc_flash_s flash_in,
	output logic [31:0]                flash_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] sram_mem  [0:8191];  // 32 kb
	logic [31:0] flash_mem [0:32767]; // full index range, upper part unused

	// sram starts with a non-zero pattern, flash blank
	initial begin
		foreach (sram_mem[i])
			sram_mem[i] = 32'hA5A5_5A5A;
		foreach (flash_mem[i])
			flash_mem[i] = 32'hFFFF_FFFF;
	end
	assign sram_rdata  = sram_mem[sram_in.addr];
	assign flash_rdata = flash_mem[flash_in.addr];

	// the cells themselves can only lose charge on program
	always @(posedge clk) begin
		if (sram_in.we)
			sram_mem[sram_in.addr] <= sram_in.wdata;
		if (flash_in.prog)
			flash_mem[flash_in.addr] <= flash_mem[flash_in.addr] & flash_in.wdata;
		if (flash_in.erase)
			for (int i = 0; i < 256; i++)
				flash_mem[{flash_in.addr[14:8], i[7:0]}] <= 32'hFFFF_FFFF;
	end
endmodule : fptc_array_model

`default_nettype wire

// >>> flash_protect_timing_ctrl_bench.sv
`default_nettype none

module flash_protect_timing_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PROG_US  = 2; // shortened program time
	localparam int ERASE_US = 3; // shortened erase time
	logic                    mclk, rstn, reg_wr, reg_rd, bus_ready, flash_irq, f;
	logic [7:0]              reg_addr;
	logic [31:0]             reg_wdata, reg_rdata, sram_rdata, flash_rdata, r;
	logic [47:0]             nv_rd, nv_pg;
	fptc_pkg::fptc_bus_req_s bus_req;
	fptc_pkg::fptc_bus_rsp_s bus_rsp;
	fptc_pkg::fptc_sram_s    sram_out;
	fptc_pkg::fptc_flash_s   flash_out;
	fptc_pkg::fptc_nv_s      nv_out;
	int                      miscompares, num_checks, prog_cyc, erase_cyc, com_n;

	fptc_top #(.PROG_US(PROG_US), .ERASE_US(ERASE_US)) fptc_top_inst (.MCLK(mclk), .RSTN(rstn),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
		.BUS_REQ(bus_req), .BUS_READY(bus_ready), .BUS_RSP(bus_rsp), .SRAM_OUT(sram_out),
		.SRAM_RDATA(sram_rdata), .FLASH_OUT(flash_out), .FLASH_RDATA(flash_rdata), .NV_RD_EN(nv_rd),
		.NV_PG_EN(nv_pg), .NV_OUT(nv_out), .FLASH_IRQ(flash_irq));
	fptc_array_model fptc_array_model_inst (.clk(mclk), .sram_in(sram_out), .sram_rdata(sram_rdata),
		.flash_in(flash_out), .flash_rdata(flash_rdata));

	// ------------------------------------------------------------
	// clock, op length counters, nonvolatile store
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		prog_cyc  <= prog_cyc + int'(flash_out.prog);
		erase_cyc <= erase_cyc + int'(flash_out.erase);
		if (nv_out.commit === 1'b1) begin
			com_n <= com_n + 1;
			if (nv_out.sel == fptc_pkg::SEL_PG0)
				nv_pg[31:0] <= nv_out.data;
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		v = reg_rdata;
		@(posedge mclk);
	endtask : rd
	// request held until taken, answer looked at mid-cycle
	task automatic bus(input logic w, input logic fe, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		bus_req <= '{1'b1, w, fe, a, d};
		@(negedge mclk);
		while (bus_ready !== 1'b1 && n < 64) begin
			n++;
			@(negedge mclk);
		end
		@(posedge mclk);
		bus_req.valid <= 1'b0;
		n = 0;
		@(negedge mclk);
		while (bus_rsp.done !== 1'b1 && n < 4) begin
			n++;
			@(negedge mclk);
		end
		chk({31'h0, bus_rsp.done}, 32'h1);
		r = bus_rsp.rdata;
		f = bus_rsp.fault;
		@(posedge mclk);
	endtask : bus
	// start a keyed flash operation and poll until its bits clear
	task automatic flash_op(input logic [31:0] tgt, input logic [31:0] d, input logic [15:0] bits);
		int n;
		wr(fptc_pkg::OFS_TARGET, tgt);
		wr(fptc_pkg::OFS_DATA, d);
		wr(fptc_pkg::OFS_CTRL, {fptc_pkg::CTRL_KEY, bits});
		n = 0;
		do begin
			rd(fptc_pkg::OFS_CTRL, r);
			n++;
		end while (r !== 32'h0 && n < 64);
		chk(r, 32'h0);
	endtask : flash_op
	task automatic do_reset;
		rstn <= 1'b0;
		repeat (4) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask : do_reset

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_defaults;
		rd(fptc_pkg::OFS_USEC, r); chk(r, 32'h18);
		rd(fptc_pkg::OFS_RD0, r);  chk(r, 32'hFFFF_FFFF);
		rd(fptc_pkg::OFS_PG0, r);  chk(r, 32'hFFFF_FFFF);
		rd(fptc_pkg::OFS_RD1, r);  chk(r, 32'h0000_FFFF);
		rd(fptc_pkg::OFS_PG1, r);  chk(r, 32'h0000_FFFF);
		rd(8'h3C, r);              chk(r, 32'h0);
	endtask : t_defaults
	task automatic t_alias;
		bus(1'b1, 1'b0, 32'h2000_1000, 32'hFFFF_FF00);
		bus(1'b1, 1'b0, 32'h2202_000C, 32'h1); // bit 3 of byte 0x1000
		bus(1'b1, 1'b0, 32'h2202_0020, 32'h0); // bit 0 of byte 0x1001
		bus(1'b0, 1'b0, 32'h2000_1000, 32'h0); chk(r, 32'hFFFF_FE08);
		bus(1'b0, 1'b0, 32'h2202_0008, 32'h0); chk({31'h0, r[0]}, 32'h0);
		bus(1'b0, 1'b0, 32'h2202_000C, 32'h0); chk({31'h0, r[0]}, 32'h1);
	endtask : t_alias
	task automatic t_program;
		int p0;
		wr(fptc_pkg::OFS_USEC, 32'h1);
		p0 = prog_cyc;
		flash_op(32'h800, 32'hF0F0_FFFF, 16'h1);
		chk(32'(prog_cyc - p0), 32'(PROG_US * 2));
		flash_op(32'h800, 32'h0FFF_F0F0, 16'h1);
		flash_op(32'h400, 32'h0, 16'h1);
		flash_op(32'hC00, 32'h0, 16'h1);
		bus(1'b0, 1'b0, 32'h800, 32'h0); chk(r, 32'h00F0_F0F0);
		rd(fptc_pkg::OFS_RAW, r); chk(r, 32'h2);
		p0 = erase_cyc;
		flash_op(32'h800, 32'h0, 16'h2);
		chk(32'(erase_cyc - p0), 32'(ERASE_US * 2));
		bus(1'b0, 1'b0, 32'h800, 32'h0); chk(r, 32'hFFFF_FFFF);
		bus(1'b0, 1'b0, 32'h400, 32'h0); chk(r, 32'h0);
	endtask : t_program
	task automatic t_irq;
		chk({31'h0, flash_irq}, 32'h0);
		wr(fptc_pkg::OFS_MASK, 32'h2);
		rd(fptc_pkg::OFS_MISC, r); chk(r, 32'h2);
		chk({31'h0, flash_irq}, 32'h1);
		wr(fptc_pkg::OFS_MISC, 32'h0);
		rd(fptc_pkg::OFS_RAW, r); chk(r, 32'h2);
		wr(fptc_pkg::OFS_MISC, 32'h2);
		rd(fptc_pkg::OFS_RAW, r); chk(r, 32'h0);
		chk({31'h0, flash_irq}, 32'h0);
	endtask : t_irq
	task automatic t_protect;
		wr(fptc_pkg::OFS_PG0, 32'hFFFF_FFFD); // locks 0x800..0xFFF
		wr(fptc_pkg::OFS_PG0, 32'hFFFF_FFFF);
		rd(fptc_pkg::OFS_PG0, r); chk(r, 32'hFFFF_FFFD);
		flash_op(32'h800, 32'h0, 16'h1);
		rd(fptc_pkg::OFS_RAW, r); chk(r, 32'h1);
		chk({31'h0, flash_irq}, 32'h0);
		flash_op(32'hC00, 32'h0, 16'h2);
		bus(1'b0, 1'b0, 32'hC00, 32'h0); chk(r, 32'h0);
		bus(1'b0, 1'b0, 32'h800, 32'h0); chk(r, 32'hFFFF_FFFF);
		wr(fptc_pkg::OFS_MASK, 32'h3);
		chk({31'h0, flash_irq}, 32'h1);
		wr(fptc_pkg::OFS_MISC, 32'h3);
		wr(fptc_pkg::OFS_RD0, 32'hFFFF_FFFD);
		bus(1'b0, 1'b0, 32'hC00, 32'h0); chk({31'h0, f}, 32'h1);
		bus(1'b0, 1'b1, 32'hC00, 32'h0); chk({f, r[30:0]}, 32'h0);
		bus(1'b0, 1'b0, 32'h1000, 32'h0); chk({31'h0, f}, 32'h0);
		bus(1'b1, 1'b0, 32'h400, 32'h0); chk({31'h0, f}, 32'h1);
		bus(1'b0, 1'b0, 32'h3000_0000, 32'h0); chk({31'h0, f}, 32'h1);
		bus(1'b0, 1'b0, 32'h1_7FFC, 32'h0); chk({31'h0, f}, 32'h0);
	endtask : t_protect
	task automatic t_commit;
		wr(fptc_pkg::OFS_TARGET, 32'h1);
		flash_op(32'h1, 32'h0, 16'h8);
		chk(32'(com_n), 32'h1);
		do_reset();
		rd(fptc_pkg::OFS_PG0, r); chk(r, 32'hFFFF_FFFD);
		rd(fptc_pkg::OFS_RD0, r); chk(r, 32'hFFFF_FFFF);
	endtask : t_commit

	// ------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic give_verdict;
		if (miscompares == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		#2_000_000;
		miscompares++;
		give_verdict();
	end
	initial begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		bus_req = '0;
		{nv_rd, nv_pg} = {96{1'b1}};
		{miscompares, num_checks, prog_cyc, erase_cyc, com_n} = '0;
		@(posedge mclk);
		do_reset();
		t_defaults();
		t_alias();
		t_program();
		t_irq();
		t_protect();
		t_commit();
		give_verdict();
	end
endmodule : flash_protect_timing_ctrl_bench

`default_nettype wire
